/* File: src/imsc_pkg.sv */
package imsc_pkg;
   // bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned LEVEL_W = 6;
   // register byte addresses
   localparam logic [7:0] ADDR_CTL2 = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_TXBUF = 8'h08;
   localparam logic [7:0] ADDR_RXBUF = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   // reset values
   localparam logic [7:0] CTL2_RESET = 8'h00;
   localparam logic MODE_RESET = 1'h0;
   // field positions
   localparam int unsigned MODE_MASTER_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_RXNE_BIT = 1;
   localparam int unsigned STAT_FULL_BIT = 2;
   localparam int unsigned STAT_LVL_LSB = 8;
   localparam int unsigned RX_VALID_BIT = 8;
   localparam int unsigned GO_SEN = 0;
   localparam int unsigned GO_RESTART_CONDITION_GO = 1;
   localparam int unsigned GO_PEN = 2;
   localparam int unsigned GO_MASTER_RECEIVE_GO = 3;
   localparam int unsigned GO_ACK_SEQUENCE_GO = 4;
   localparam int unsigned ACK_VALUE_TO_SEND_BIT = 5;
   localparam int unsigned GENERAL_CALL_IRQ_ENABLE_BIT = 7;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing: one bit on the line is four quarter slots
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned BIT_TIME_NS = 10000;
   localparam int unsigned QUARTERS = 4;
   localparam int unsigned QTR_CYC = BIT_TIME_NS / (QUARTERS * CLK_PERIOD_NS);
   localparam int unsigned QTR_CNT_W = 8;
   // index of the last bit slot of each operation
   localparam logic [3:0] LAST_TX = 4'h8;
   localparam logic [3:0] LAST_RX = 4'h7;
   localparam logic [3:0] LAST_ONE = 4'h0;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   typedef struct packed {
      logic general_call_irq_enable;
      logic ack_received_status;
      logic ack_value_to_send;
      logic ack_sequence_go;
      logic master_receive_go;
      logic stop_condition_go;
      logic restart_condition_go;
      logic start_go_or_stretch_enable;
   } imsc_ctl2_s;

   typedef struct packed {
      logic scl_low;
      logic sda_low;
   } imsc_drive_s;

   typedef enum logic [2:0] {OP_START, OP_RSTART, OP_STOP, OP_RX, OP_ACK, OP_TX} imsc_op_e;
   typedef enum logic {ST_IDLE, ST_RUN} imsc_state_e;
endpackage

/* File: src/imsc_tick_div.sv */
`timescale 1ns/1ps
`default_nettype none
module imsc_tick_div
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   output logic tick
);
   logic [imsc_pkg::QTR_CNT_W-1:0] cnt_q;
   logic [imsc_pkg::QTR_CNT_W-1:0] cnt_d;
   localparam logic [imsc_pkg::QTR_CNT_W-1:0] TOP = imsc_pkg::QTR_CNT_W'(imsc_pkg::QTR_CYC - 1);

   // restart from zero when idle so the first slot is always full length
   always_comb
   begin
      tick = run && (cnt_q == TOP);
      if (!run || tick)
         cnt_d = '0;
      else
         cnt_d = cnt_q + 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
endmodule
`default_nettype wire

/* File: src/imsc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module imsc_fifo
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] wr_d;
   logic [AW-1:0] rd_q;
   logic [AW-1:0] rd_d;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic push;
   logic pop;

   // pointers wrap naturally since depth is a power of two
   always_comb
   begin
      in_ready = (cnt_q != (AW+1)'(DEPTH));
      out_valid = (cnt_q != '0);
      out_data = mem[rd_q];
      level = cnt_q;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge aclk)
   begin
      if (push)
         mem[wr_q] <= in_data;
      if (!aresetn)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

/* File: src/imsc_core.sv */
// Overview of operation
// - The acknowledge-sequence go bit acts only in master mode, to answer a byte just received.
// - Setting the acknowledge go bit drives one acknowledge slot carrying the stored ack value, then hardware clears the bit.
// - Setting the receive go bit in master mode clocks in one byte from the slave unless the receive buffer is full; at zero, receive is idle.
// - Setting the stop go bit in master mode drives a Stop condition; while it reads zero no Stop runs.
// - Hardware clears the stop go bit itself once its Stop condition has finished on the lines.
// - Setting the repeated-start go bit in master mode drives a Repeated Start, then hardware clears it.
// - Go bits and buffer writes are only accepted while the engine is idle; nothing is queued while busy.
`timescale 1ns/1ps
`default_nettype none
module imsc_core
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic serial_clock_line_i,
   output logic serial_clock_line_o,
   output logic serial_clock_line_oe,
   input wire logic serial_data_line_i,
   output logic serial_data_line_o,
   output logic serial_data_line_oe,
   output logic stretch_enable
);
   // bus side state
   logic aw_have_q, aw_have_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic w_have_q, w_have_d;
   logic [7:0] wbyte_q, wbyte_d;
   logic wlane_q, wlane_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   imsc_pkg::imsc_ctl2_s ctl_q, ctl_d;
   logic master_q, master_d;
   logic start_go;
   imsc_pkg::imsc_op_e start_op;
   logic rx_pop;
   // engine state
   imsc_pkg::imsc_state_e st_q, st_d;
   imsc_pkg::imsc_op_e op_q, op_d;
   logic [1:0] qtr_q, qtr_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic ack_q, ack_d;
   imsc_pkg::imsc_drive_s drv_q, drv_d;
   logic eng_done;
   logic idle;
   logic tick;
   logic send_bit;
   // receive buffer
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic [imsc_pkg::LEVEL_W-1:0] fifo_level;

   // last bit slot index of an operation
   function automatic logic [3:0] last_slot(input imsc_pkg::imsc_op_e op);
      case (op)
         imsc_pkg::OP_TX: last_slot = imsc_pkg::LAST_TX;
         imsc_pkg::OP_RX: last_slot = imsc_pkg::LAST_RX;
         default: last_slot = imsc_pkg::LAST_ONE;
      endcase
   endfunction

   // line levels for each quarter slot; bit slots put data on sda while scl is low
   function automatic imsc_pkg::imsc_drive_s line_drive(input imsc_pkg::imsc_op_e op,
                                                        input logic [1:0] qtr,
                                                        input logic b);
      imsc_pkg::imsc_drive_s d;
      d.scl_low = 1'b0;
      d.sda_low = 1'b0;
      case (op)
         imsc_pkg::OP_START:
         begin
            d.sda_low = qtr[1];
            d.scl_low = (qtr == 2'h3);
         end
         imsc_pkg::OP_RSTART:
         begin
            d.sda_low = qtr[1];
            d.scl_low = (qtr == 2'h0) || (qtr == 2'h3);
         end
         imsc_pkg::OP_STOP:
         begin
            d.sda_low = (qtr != 2'h3);
            d.scl_low = (qtr == 2'h0);
         end
         default:
         begin
            d.sda_low = !b;
            d.scl_low = (qtr == 2'h0) || (qtr == 2'h3);
         end
      endcase
      return d;
   endfunction

   assign idle = (st_q == imsc_pkg::ST_IDLE);
   // handshake outputs combinational, one write and one read in flight
   assign awready = !aw_have_q && !bvalid_q;
   assign wready = !w_have_q && !bvalid_q;
   assign arready = !rvalid_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   // open drain: only ever pull low
   assign serial_clock_line_o = 1'b0;
   assign serial_data_line_o = 1'b0;
   assign serial_clock_line_oe = drv_q.scl_low;
   assign serial_data_line_oe = drv_q.sda_low;
   assign stretch_enable = !master_q && ctl_q.start_go_or_stretch_enable;

   // register file, write and read channels
   always_comb
   begin
      aw_have_d = aw_have_q;
      awaddr_d = awaddr_q;
      w_have_d = w_have_q;
      wbyte_d = wbyte_q;
      wlane_d = wlane_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      ctl_d = ctl_q;
      master_d = master_q;
      start_go = 1'b0;
      start_op = imsc_pkg::OP_START;
      rx_pop = 1'b0;
      if (awvalid && awready)
      begin
         aw_have_d = 1'b1;
         awaddr_d = awaddr;
      end
      if (wvalid && wready)
      begin
         w_have_d = 1'b1;
         wbyte_d = wdata[7:0];
         wlane_d = wstrb[0];
      end
      // completion clears the go bit of the finished step
      if (eng_done)
      begin
         case (op_q)
            imsc_pkg::OP_START: ctl_d.start_go_or_stretch_enable = 1'b0;
            imsc_pkg::OP_RSTART: ctl_d.restart_condition_go = 1'b0;
            imsc_pkg::OP_STOP: ctl_d.stop_condition_go = 1'b0;
            imsc_pkg::OP_RX: ctl_d.master_receive_go = 1'b0;
            imsc_pkg::OP_ACK: ctl_d.ack_sequence_go = 1'b0;
            imsc_pkg::OP_TX: ctl_d.ack_received_status = ack_q;
            default: ctl_d.ack_received_status = ctl_q.ack_received_status;
         endcase
      end
      if (aw_have_q && w_have_q && !bvalid_q)
      begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = imsc_pkg::RESP_OKAY;
         case (awaddr_q)
            imsc_pkg::ADDR_CTL2:
               if (wlane_q)
               begin
                  ctl_d.general_call_irq_enable = wbyte_q[imsc_pkg::GENERAL_CALL_IRQ_ENABLE_BIT];
                  ctl_d.ack_value_to_send = wbyte_q[imsc_pkg::ACK_VALUE_TO_SEND_BIT];
                  if (!master_q)
                     ctl_d.start_go_or_stretch_enable = wbyte_q[imsc_pkg::GO_SEN];
                  else if (idle)
                  begin
                     // one step per write; lowest bit wins, except that the receive bit is skipped while the buffer is full; the rest are dropped
                     start_go = 1'b1;
                     if (wbyte_q[imsc_pkg::GO_SEN])
                     begin
                        ctl_d.start_go_or_stretch_enable = 1'b1;
                        start_op = imsc_pkg::OP_START;
                     end
                     else if (wbyte_q[imsc_pkg::GO_RESTART_CONDITION_GO])
                     begin
                        ctl_d.restart_condition_go = 1'b1;
                        start_op = imsc_pkg::OP_RSTART;
                     end
                     else if (wbyte_q[imsc_pkg::GO_PEN])
                     begin
                        ctl_d.stop_condition_go = 1'b1;
                        start_op = imsc_pkg::OP_STOP;
                     end
                     else if (wbyte_q[imsc_pkg::GO_MASTER_RECEIVE_GO] && fifo_in_ready)
                     begin
                        ctl_d.master_receive_go = 1'b1;
                        start_op = imsc_pkg::OP_RX;
                     end
                     else if (wbyte_q[imsc_pkg::GO_ACK_SEQUENCE_GO])
                     begin
                        ctl_d.ack_sequence_go = 1'b1;
                        start_op = imsc_pkg::OP_ACK;
                     end
                     else
                        start_go = 1'b0;
                  end
               end
            imsc_pkg::ADDR_MODE:
               if (wlane_q && idle)
                  master_d = wbyte_q[imsc_pkg::MODE_MASTER_BIT];
            imsc_pkg::ADDR_TXBUF:
               if (wlane_q && master_q && idle)
               begin
                  start_go = 1'b1;
                  start_op = imsc_pkg::OP_TX;
               end
            imsc_pkg::ADDR_RXBUF, imsc_pkg::ADDR_STATUS:
               bresp_d = imsc_pkg::RESP_OKAY;
            default:
               bresp_d = imsc_pkg::RESP_SLVERR;
         endcase
      end
      if (bvalid_q && bready)
         bvalid_d = 1'b0;
      if (arvalid && arready)
      begin
         rvalid_d = 1'b1;
         rresp_d = imsc_pkg::RESP_OKAY;
         rdata_d = '0;
         case (araddr)
            imsc_pkg::ADDR_CTL2: rdata_d[7:0] = ctl_q;
            imsc_pkg::ADDR_MODE: rdata_d[imsc_pkg::MODE_MASTER_BIT] = master_q;
            imsc_pkg::ADDR_TXBUF: rdata_d[7:0] = sh_q;
            imsc_pkg::ADDR_RXBUF:
               if (fifo_out_valid)
               begin
                  // reading pops; an empty buffer reads with the valid bit low
                  rdata_d[7:0] = fifo_out_data;
                  rdata_d[imsc_pkg::RX_VALID_BIT] = 1'b1;
                  rx_pop = 1'b1;
               end
            imsc_pkg::ADDR_STATUS:
            begin
               rdata_d[imsc_pkg::STAT_BUSY_BIT] = !idle;
               rdata_d[imsc_pkg::STAT_RXNE_BIT] = fifo_out_valid;
               rdata_d[imsc_pkg::STAT_FULL_BIT] = !fifo_in_ready;
               rdata_d[imsc_pkg::STAT_LVL_LSB +: imsc_pkg::LEVEL_W] = fifo_level;
            end
            default: rresp_d = imsc_pkg::RESP_SLVERR;
         endcase
      end
      else if (rvalid_q && rready)
         rvalid_d = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         w_have_q <= 1'b0;
         wbyte_q <= 8'h00;
         wlane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= imsc_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= imsc_pkg::RESP_OKAY;
         ctl_q <= imsc_pkg::CTL2_RESET;
         master_q <= imsc_pkg::MODE_RESET;
      end
      else
      begin
         aw_have_q <= aw_have_d;
         awaddr_q <= awaddr_d;
         w_have_q <= w_have_d;
         wbyte_q <= wbyte_d;
         wlane_q <= wlane_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         ctl_q <= ctl_d;
         master_q <= master_d;
      end
   end

   // bit to put on sda: data msb first, own ack value, else release
   always_comb
   begin
      if (op_q == imsc_pkg::OP_TX && bit_q != imsc_pkg::ACK_SLOT)
         send_bit = sh_q[7];
      else if (op_q == imsc_pkg::OP_ACK)
         send_bit = ctl_q.ack_value_to_send;
      else
         send_bit = 1'b1;
   end

   // line engine: each step is a run of bit slots of four quarters
   always_comb
   begin
      st_d = st_q;
      op_d = op_q;
      qtr_d = qtr_q;
      bit_d = bit_q;
      sh_d = sh_q;
      ack_d = ack_q;
      drv_d = drv_q;
      eng_done = 1'b0;
      unique case (st_q)
         imsc_pkg::ST_IDLE:
            if (start_go)
            begin
               st_d = imsc_pkg::ST_RUN;
               op_d = start_op;
               qtr_d = 2'h0;
               bit_d = 4'h0;
               sh_d = (start_op == imsc_pkg::OP_TX) ? wbyte_q : 8'h00;
            end
         imsc_pkg::ST_RUN:
            if (tick)
            begin
               drv_d = line_drive(op_q, qtr_q, send_bit);
               // sample mid-high of scl
               if (qtr_q == 2'h2 && op_q == imsc_pkg::OP_RX)
                  sh_d = {sh_q[6:0], serial_data_line_i};
               if (qtr_q == 2'h2 && op_q == imsc_pkg::OP_TX && bit_q == imsc_pkg::ACK_SLOT)
                  ack_d = serial_data_line_i;
               if (qtr_q == 2'h3 && op_q == imsc_pkg::OP_TX)
                  sh_d = {sh_q[6:0], 1'b0};
               if (qtr_q == 2'h3)
               begin
                  qtr_d = 2'h0;
                  bit_d = bit_q + 4'h1;
                  if (bit_q == last_slot(op_q))
                  begin
                     eng_done = 1'b1;
                     st_d = imsc_pkg::ST_IDLE;
                  end
               end
               else
                  qtr_d = qtr_q + 2'h1;
            end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q <= imsc_pkg::ST_IDLE;
         op_q <= imsc_pkg::OP_START;
         qtr_q <= 2'h0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         ack_q <= 1'b0;
         drv_q <= 2'h0;
      end
      else
      begin
         st_q <= st_d;
         op_q <= op_d;
         qtr_q <= qtr_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         ack_q <= ack_d;
         drv_q <= drv_d;
      end
   end

   imsc_tick_div u_div
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(!idle),
      .tick(tick)
   );

   // received bytes; a full buffer refuses new receive steps
   imsc_fifo #(.WIDTH(imsc_pkg::BYTE_W), .DEPTH(imsc_pkg::FIFO_DEPTH)) u_rx_fifo
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(eng_done && op_q == imsc_pkg::OP_RX),
      .in_ready(fifo_in_ready),
      .in_data(sh_q),
      .out_valid(fifo_out_valid),
      .out_ready(rx_pop),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );
endmodule
`default_nettype wire

/* File: tb/imsc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module imsc_monitor
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic serial_clock_line_oe,
   input wire logic serial_data_line_oe,
   input wire logic stretch_enable
);
   logic [1:0] oe_q;
   logic [1:0] oe_d;
   logic [9:0] gap_q;
   logic [9:0] gap_d;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // cycles since a line moved; saturates so long idle time cannot wrap
   always_comb
   begin
      oe_d = {serial_clock_line_oe, serial_data_line_oe};
      gap_d = (gap_q == 10'h3ff) ? gap_q : gap_q + 10'h1;
      if (oe_d != oe_q)
         gap_d = 10'h0;
      if (!aresetn)
      begin
         oe_d = 2'h0;
         gap_d = 10'h3ff;
      end
   end
   // state only
   always_ff @(posedge aclk)
   begin
      oe_q <= oe_d;
      gap_q <= gap_d;
   end
   property p_wr_answer; awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer off");
   property p_b_once; bvalid && bready |=> !bvalid; endproperty
   a_b_once: assert property (p_b_once) else $error("second write answer");
   property p_b_block; bvalid |-> !awready && !wready; endproperty
   a_b_block: assert property (p_b_block) else $error("write taken while answering");
   property p_rd_answer; arvalid && arready |=> rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_slave_quiet; stretch_enable |-> !serial_clock_line_oe && !serial_data_line_oe; endproperty
   a_slave_quiet: assert property (p_slave_quiet) else $error("lines driven in slave mode");
   property p_line_pace; oe_d != oe_q |-> gap_q >= 10'h0f9; endproperty
   a_line_pace: assert property (p_line_pace) else $error("line moved off quarter");
   property p_start_shape;
      $rose(serial_data_line_oe) && !serial_clock_line_oe |-> ##250 $rose(serial_clock_line_oe);
   endproperty
   a_start_shape: assert property (p_start_shape) else $error("start shape wrong");
   property p_stop_idle;
      $fell(serial_data_line_oe) && !serial_clock_line_oe |=>
         (!serial_clock_line_oe && !serial_data_line_oe)[*8];
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("lines busy after stop");
   cover property (stretch_enable);
   cover property (bvalid && bresp == imsc_pkg::RESP_SLVERR);
   cover property ($fell(serial_data_line_oe) && !serial_clock_line_oe);
endmodule
bind imsc_core imsc_monitor u_imsc_monitor (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .serial_clock_line_oe(serial_clock_line_oe), .serial_data_line_oe(serial_data_line_oe),
   .stretch_enable(stretch_enable));
`default_nettype wire

/* File: tb/imsc_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module imsc_slave_model
(
   input wire logic scl,
   input wire logic sda,
   input wire logic send_mode,
   input wire logic ack_on,
   input wire logic [7:0] send_byte,
   output logic sda_oe,
   output logic [7:0] got_byte
);
   int idx = 0;
   logic nack = 1'b0;
   initial sda_oe = 1'b0;
   initial got_byte = 8'h00;
   // start or stop restarts framing and lets go of data
   always @(sda)
      if (scl)
      begin
         idx = 0;
         nack = 1'b0;
         sda_oe = 1'b0;
      end
   // sample on rising clock; a refused byte ends our sending
   always @(posedge scl)
   begin
      if (idx < 8)
         got_byte = {got_byte[6:0], sda};
      else if (send_mode && sda)
         nack = 1'b1;
      idx = (idx + 1) % 9;
   end
   // data only moves while the clock is low
   always @(negedge scl)
      if (send_mode)
         sda_oe = !nack && idx < 8 && !send_byte[7 - idx];
      else
         sda_oe = idx == 8 && ack_on;
endmodule
`default_nettype wire

/* File: tb/tb_i2c_master_sequence_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) \
      begin \
         err_total++; \
         $display("Error at %0t: got %0h expected %0h", $time, g, e); \
      end \
   end
module tb_i2c_master_sequence_control;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, sl_oe, stretch;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, got, tx_byte, send_byte = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rdv;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp, rsp;
   logic send_mode = 1'b0, ack_on = 1'b1, sda_hi = 1'b0;
   int err_total = 0;
   int cmp_count = 0;
   wire scl_w = !scl_oe;
   wire sda_w = !(sda_oe || sl_oe);
   // clock, 10 ns period
   always #5 aclk = !aclk;
   // data level while the clock line is high
   always @(posedge scl_w) sda_hi = sda_w;
   imsc_core u_imsc_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .serial_clock_line_i(scl_w), .serial_clock_line_o(), .serial_clock_line_oe(scl_oe),
      .serial_data_line_i(sda_w), .serial_data_line_o(), .serial_data_line_oe(sda_oe),
      .stretch_enable(stretch));
   imsc_slave_model u_imsc_slave_model (.scl(scl_w), .sda(sda_w), .send_mode(send_mode),
      .ack_on(ack_on), .send_byte(send_byte), .sda_oe(sl_oe), .got_byte(got));
   task automatic print_verdict;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // a wait that runs out counts against the run
   task automatic give_up;
      err_total++;
      print_verdict();
   endtask
   // places past the status word are unmapped
   function automatic logic [1:0] exp_resp(input logic [7:0] a);
      return (a > imsc_pkg::ADDR_STATUS) ? imsc_pkg::RESP_SLVERR : imsc_pkg::RESP_OKAY;
   endfunction
   function automatic logic [31:0] exp_rx(input logic [7:0] b);
      return 32'(b) | (32'h1 << imsc_pkg::RX_VALID_BIT);
   endfunction
   function automatic logic [7:0] ctl_idle(input logic nak);
      return {1'b0, nak, 6'h00};
   endfunction
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      bready <= 1'b0;
      if (n == 50)
         give_up();
      `CHK(bresp, exp_resp(a))
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      rdv = rdata;
      rsp = rresp;
      rready <= 1'b0;
      if (n == 50)
         give_up();
   endtask
   // poll busy; a whole byte is some 9000 cycles
   task automatic wait_idle;
      int n;
      for (n = 0; n < 8000; n++)
      begin
         rd(imsc_pkg::ADDR_STATUS);
         if (rdv[imsc_pkg::STAT_BUSY_BIT] === 1'b0)
            break;
      end
      if (n == 8000)
         give_up();
   endtask
   initial
   begin
      void'($urandom(32'h52af));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values, then an unmapped place
      rd(imsc_pkg::ADDR_CTL2);
      `CHK(rdv, 32'h0)
      rd(imsc_pkg::ADDR_MODE);
      `CHK(rdv, 32'h0)
      rd(8'h14);
      `CHK({rsp, rdv}, {imsc_pkg::RESP_SLVERR, 32'h0})
      wr(8'h14, 32'h1);
      $display("test reset_map done");
      // slave mode: start bit is a stretch enable, ack go is dropped
      wr(imsc_pkg::ADDR_CTL2, 32'h1);
      rd(imsc_pkg::ADDR_CTL2);
      `CHK({rdv[0], stretch}, 2'b11)
      wr(imsc_pkg::ADDR_CTL2, 32'h10);
      rd(imsc_pkg::ADDR_CTL2);
      `CHK(rdv[7:0], 8'h00)
      `CHK(stretch, 1'b0)
      $display("test slave_mode done");
      // master start; a restart while busy is dropped
      wr(imsc_pkg::ADDR_MODE, 32'h1);
      wr(imsc_pkg::ADDR_CTL2, 32'h1);
      wr(imsc_pkg::ADDR_CTL2, 32'h2);
      rd(imsc_pkg::ADDR_CTL2);
      `CHK(rdv[1:0], 2'b01)
      wait_idle();
      rd(imsc_pkg::ADDR_CTL2);
      `CHK(rdv[7:0], 8'h00)
      `CHK({scl_oe, sda_oe}, 2'b11)
      $display("test start done");
      // two bytes out, a refused overwrite each, second not acknowledged
      for (int k = 0; k < 2; k++)
      begin
         tx_byte = (k == 0) ? 8'h01 : 8'($urandom);
         ack_on <= (k == 0);
         wr(imsc_pkg::ADDR_TXBUF, {24'h0, tx_byte});
         wr(imsc_pkg::ADDR_TXBUF, {24'h0, ~tx_byte});
         wait_idle();
         `CHK(got, tx_byte)
         rd(imsc_pkg::ADDR_CTL2);
         `CHK(rdv[7:0], ctl_idle(k != 0))
      end
      $display("test transmit done");
      // repeated start, then one random byte in
      send_mode <= 1'b1;
      send_byte <= 8'($urandom);
      wr(imsc_pkg::ADDR_CTL2, 32'h2);
      wait_idle();
      rd(imsc_pkg::ADDR_CTL2);
      `CHK({rdv[1], scl_oe, sda_oe}, 3'b011)
      wr(imsc_pkg::ADDR_CTL2, 32'h8);
      wait_idle();
      // last status poll: one byte waiting, not busy, not full
      `CHK(rdv, 32'h0000_0102)
      rd(imsc_pkg::ADDR_RXBUF);
      `CHK(rdv, exp_rx(send_byte))
      rd(imsc_pkg::ADDR_RXBUF);
      `CHK(rdv, 32'h0000_0000)
      // refuse the byte, then stop
      wr(imsc_pkg::ADDR_CTL2, 32'h30);
      wait_idle();
      rd(imsc_pkg::ADDR_CTL2);
      `CHK({rdv[5:3], sda_hi}, 4'b1001)
      wr(imsc_pkg::ADDR_CTL2, 32'h4);
      rd(imsc_pkg::ADDR_CTL2);
      `CHK(rdv[2], 1'b1)
      wait_idle();
      rd(imsc_pkg::ADDR_CTL2);
      `CHK(rdv[2], 1'b0)
      `CHK({scl_oe, sda_oe, sda_w}, 3'b001)
      $display("test receive_stop done");
      print_verdict();
   end
endmodule
`default_nettype wire
